// ==== seie_cfg.svh ====
// constants for the serial eeprom instruction engine
// assumes a 250 MHz system clock and a master that drives select, clock and data
`ifndef SEIE_CFG_SVH
`define SEIE_CFG_SVH

`define SEIE_AW 8
`define SEIE_DW 16
`define SEIE_PAGE_WORDS 4
`define SEIE_OPC_BITS 2

// --------------------------------------------------------------
// instruction encodings
// --------------------------------------------------------------
`define SEIE_OP_READ 2'h2
`define SEIE_OP_WRITE 2'h1
`define SEIE_OP_PAGE 2'h3
`define SEIE_OP_MISC 2'h0
`define SEIE_SUB_ON 2'h3
`define SEIE_SUB_OFF 2'h0
`define SEIE_SUB_FILL 2'h1
`define SEIE_ADDR_ONES 8'hFF
`define SEIE_ADDR_ZERO 8'h00

// --------------------------------------------------------------
// timing
// --------------------------------------------------------------
`define SEIE_CLK_MHZ 250
`define SEIE_TW_US 10000
`define SEIE_TSLSH_NS 250
`define SEIE_SYNC_DEPTH 3

// --------------------------------------------------------------
// reset values
// --------------------------------------------------------------
`define SEIE_BND_RST 8'hFF
`define SEIE_FLAG_RST 1'b1
`define SEIE_ERASED 16'hFFFF
`define SEIE_PORT_EN_RST 1'b1

// --------------------------------------------------------------
// register map, byte offsets, and fields
// --------------------------------------------------------------
`define SEIE_REG_STATUS 5'h00
`define SEIE_REG_CTRL 5'h04
`define SEIE_REG_BOUND 5'h08
`define SEIE_REG_MADDR 5'h0C
`define SEIE_REG_MDATA 5'h10
`define SEIE_ST_BUSY 0
`define SEIE_ST_WEL 1
`define SEIE_ST_FLAG 2
`define SEIE_ST_OTP 3
`define SEIE_ST_ARMED 4
`define SEIE_CTRL_PORT_EN 0

`endif

// ==== seie_pkg.sv ====
// types for the serial eeprom instruction engine
// assumes seie_cfg.svh is on the include path
`include "seie_cfg.svh"

package seie_pkg;

  // --------------------------------------------------------------
  // serial pins as seen by the device
  // --------------------------------------------------------------
  typedef struct packed {
    logic sel;
    logic sclk;
    logic sdi;
    logic pre;
    logic wp;
  } seie_pins_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_OPC,
    ST_ADDR,
    ST_DATA,
    ST_LAST,
    ST_READ,
    ST_PROG,
    ST_READY,
    ST_SKIP
  } seie_state_t;

endpackage

// ==== seie_engine.sv ====
// serial eeprom instruction engine: decoder, sequencer, array and avalon slave
// assumes pins come from another clock domain; avalon master on i_clk_sys
`timescale 1ns/1ps
`include "seie_cfg.svh"

module seie_engine #(
  parameter int unsigned TW_CYC = `SEIE_TW_US * `SEIE_CLK_MHZ,
  parameter int AW = `SEIE_AW,
  parameter int DW = `SEIE_DW,
  parameter int PW = `SEIE_PAGE_WORDS
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire seie_pkg::seie_pins_t i_pins,
  output logic o_sdo,
  output logic o_sdo_oe,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest
);
  import seie_pkg::*;

  localparam int TSLSH_CYC = (`SEIE_TSLSH_NS * `SEIE_CLK_MHZ + 999) / 1000;
  localparam int WORDS = 1 << AW;

  // --------------------------------------------------------------
  // pin synchroniser and filter
  // --------------------------------------------------------------
  seie_pins_t sync1_r, sync2_r, sync3_r, filt_r, filt_nxt;

  always_comb begin
    filt_nxt = (sync2_r & sync3_r) | (filt_r & (sync2_r | sync3_r));
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
      filt_r <= '0;
    end else begin
      sync1_r <= i_pins;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      filt_r <= filt_nxt;
    end
  end

  // --------------------------------------------------------------
  // shared state
  // --------------------------------------------------------------
  seie_state_t state_r;
  logic port_en_r, wel_r, armed_r, flag_r, otp_r, wp_ok_r, stream_r;
  logic [AW-1:0] bnd_r, addr_sh_r, rd_addr_r, maddr_r;
  logic [1:0] op_r;
  logic [4:0] cnt_r;
  logic [2:0] pidx_r;
  logic [DW-1:0] sh_r, dsh_r;
  logic [DW-1:0] pbuf_r [PW];
  logic [DW-1:0] mem_r [WORDS];
  logic [31:0] tmr_r;
  logic sdo_r, oe_r, ack_r;
  logic sel, rise, din, pre, addr_done, go_prog, prog_ok;
  logic [AW-1:0] a_full;

  function automatic logic prot_hit(input logic [AW-1:0] a, input logic [AW-1:0] b,
                                    input logic f);
    prot_hit = !f && (a >= b);
  endfunction

  function automatic logic [AW-1:0] page_addr(input logic [AW-1:0] base, input int i);
    logic [1:0] lo;
    lo = base[1:0] + 2'(i);
    page_addr = {base[AW-1:2], lo};
  endfunction

  // --------------------------------------------------------------
  // decode
  // --------------------------------------------------------------
  always_comb begin
    sel = filt_r.sel & port_en_r;
    rise = filt_nxt.sclk & ~filt_r.sclk;
    din = filt_nxt.sdi;
    pre = filt_r.pre;
    a_full = {addr_sh_r[AW-2:0], din};
    addr_done = (state_r == ST_ADDR) && sel && rise && (cnt_r == 5'(AW - 1));
  end

  always_comb begin
    prog_ok = wel_r & wp_ok_r;
    if (op_r == `SEIE_OP_WRITE) begin
      if (prot_hit(addr_sh_r, bnd_r, flag_r)) begin
        prog_ok = 1'b0;
      end
    end else if (op_r == `SEIE_OP_PAGE) begin
      for (int i = 0; i < PW; i++) begin
        if (3'(i) < pidx_r && prot_hit(page_addr(addr_sh_r, i), bnd_r, flag_r)) begin
          prog_ok = 1'b0;
        end
      end
    end else if (!flag_r) begin
      prog_ok = 1'b0;
    end
    go_prog = (state_r == ST_LAST) && !sel && prog_ok;
  end

  // --------------------------------------------------------------
  // instruction sequencer
  // --------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
      op_r <= '0;
      addr_sh_r <= '0;
      rd_addr_r <= '0;
      sh_r <= '0;
      dsh_r <= '0;
      pidx_r <= '0;
      stream_r <= 1'b0;
      tmr_r <= '0;
      sdo_r <= 1'b0;
      for (int i = 0; i < PW; i++) begin
        pbuf_r[i] <= '0;
      end
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (sel && rise && din) begin
            state_r <= ST_OPC;
            cnt_r <= '0;
          end
        end
        ST_OPC: begin
          if (!sel) begin
            state_r <= ST_IDLE;
          end else if (rise) begin
            op_r <= {op_r[0], din};
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r == 5'(`SEIE_OPC_BITS - 1)) begin
              state_r <= ST_ADDR;
              cnt_r <= '0;
            end
          end
        end
        ST_ADDR: begin
          if (!sel) begin
            state_r <= ST_IDLE;
          end else if (rise) begin
            addr_sh_r <= a_full;
            cnt_r <= cnt_r + 5'h01;
            if (addr_done) begin
              cnt_r <= '0;
              pidx_r <= '0;
              if (op_r == `SEIE_OP_READ) begin
                state_r <= ST_READ;
                sdo_r <= 1'b0;
                rd_addr_r <= a_full;
                stream_r <= !pre;
                if (pre) begin
                  sh_r <= {bnd_r, flag_r, {(DW - AW - 1){1'b0}}};
                end else begin
                  sh_r <= mem_r[a_full];
                end
              end else if (!pre && (op_r != `SEIE_OP_MISC ||
                                    a_full[AW-1 -: 2] == `SEIE_SUB_FILL)) begin
                state_r <= ST_DATA;
              end else begin
                state_r <= ST_SKIP;
              end
            end
          end
        end
        ST_DATA: begin
          if (!sel) begin
            state_r <= ST_IDLE;
          end else if (rise) begin
            dsh_r <= {dsh_r[DW-2:0], din};
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r == 5'(DW - 1)) begin
              pbuf_r[pidx_r[1:0]] <= {dsh_r[DW-2:0], din};
              pidx_r <= pidx_r + 3'h1;
              state_r <= ST_LAST;
            end
          end
        end
        ST_LAST: begin
          if (!sel) begin
            state_r <= go_prog ? ST_PROG : ST_IDLE;
            tmr_r <= '0;
            sdo_r <= 1'b0;
          end else if (rise) begin
            if (op_r == `SEIE_OP_PAGE && pidx_r != 3'(PW)) begin
              dsh_r <= {dsh_r[DW-2:0], din};
              cnt_r <= 5'h01;
              state_r <= ST_DATA;
            end else begin
              state_r <= ST_SKIP;
            end
          end
        end
        ST_READ: begin
          if (!sel) begin
            state_r <= ST_IDLE;
          end else if (rise) begin
            sdo_r <= sh_r[DW-1];
            sh_r <= {sh_r[DW-2:0], 1'b0};
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r == 5'(DW - 1)) begin
              cnt_r <= '0;
              if (stream_r) begin
                rd_addr_r <= AW'(rd_addr_r + 1'b1);
                sh_r <= mem_r[AW'(rd_addr_r + 1'b1)];
              end
            end
          end
        end
        ST_PROG: begin
          tmr_r <= tmr_r + 32'h1;
          sdo_r <= 1'b0;
          if (tmr_r == TW_CYC - 1) begin
            state_r <= sel ? ST_READY : ST_IDLE;
            sdo_r <= 1'b1;
          end
        end
        ST_READY: begin
          sdo_r <= 1'b1;
          if (!sel) begin
            state_r <= ST_IDLE;
          end else if (rise && din) begin
            state_r <= ST_OPC;
            cnt_r <= '0;
          end
        end
        ST_SKIP: begin
          if (!sel) begin
            state_r <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // output pin
  // --------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      oe_r <= 1'b0;
    end else begin
      oe_r <= sel && (state_r == ST_READ || state_r == ST_READY ||
                      (state_r == ST_PROG && tmr_r >= 32'(TSLSH_CYC)));
    end
  end

  assign o_sdo = sdo_r;
  assign o_sdo_oe = oe_r;

  // --------------------------------------------------------------
  // write latch and protection state
  // --------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      wel_r <= 1'b0;
      armed_r <= 1'b0;
      bnd_r <= `SEIE_BND_RST;
      flag_r <= `SEIE_FLAG_RST;
      otp_r <= 1'b0;
      wp_ok_r <= 1'b0;
    end else begin
      if (state_r == ST_IDLE || state_r == ST_READY) begin
        wp_ok_r <= filt_r.wp;
      end else begin
        wp_ok_r <= wp_ok_r & filt_r.wp;
      end
      if (addr_done) begin
        armed_r <= 1'b0;
        if (!pre && op_r == `SEIE_OP_MISC) begin
          if (a_full[AW-1 -: 2] == `SEIE_SUB_ON && wp_ok_r) begin
            wel_r <= 1'b1;
          end else if (a_full[AW-1 -: 2] == `SEIE_SUB_OFF) begin
            wel_r <= 1'b0;
          end
        end else if (pre && wel_r && wp_ok_r && !otp_r) begin
          if (op_r == `SEIE_OP_MISC && a_full[AW-1 -: 2] == `SEIE_SUB_ON) begin
            armed_r <= 1'b1;
          end else if (armed_r && op_r == `SEIE_OP_WRITE) begin
            bnd_r <= a_full;
            flag_r <= 1'b0;
          end else if (armed_r && op_r == `SEIE_OP_PAGE && a_full == `SEIE_ADDR_ONES) begin
            bnd_r <= `SEIE_ADDR_ONES;
            flag_r <= 1'b1;
          end else if (armed_r && op_r == `SEIE_OP_MISC && a_full == `SEIE_ADDR_ZERO) begin
            otp_r <= 1'b1;
          end
        end
      end
    end
  end

  // --------------------------------------------------------------
  // array
  // --------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      for (int i = 0; i < WORDS; i++) begin
        mem_r[i] <= `SEIE_ERASED;
      end
    end else if (go_prog) begin
      if (op_r == `SEIE_OP_WRITE) begin
        mem_r[addr_sh_r] <= pbuf_r[0];
      end else if (op_r == `SEIE_OP_PAGE) begin
        for (int i = 0; i < PW; i++) begin
          if (3'(i) < pidx_r) begin
            mem_r[page_addr(addr_sh_r, i)] <= pbuf_r[i];
          end
        end
      end else begin
        for (int i = 0; i < WORDS; i++) begin
          mem_r[i] <= pbuf_r[0];
        end
      end
    end
  end

  // --------------------------------------------------------------
  // avalon slave
  // --------------------------------------------------------------
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    unique case (i_avs_address)
      `SEIE_REG_STATUS: begin
        rd_mux[`SEIE_ST_BUSY] = (state_r == ST_PROG);
        rd_mux[`SEIE_ST_WEL] = wel_r;
        rd_mux[`SEIE_ST_FLAG] = flag_r;
        rd_mux[`SEIE_ST_OTP] = otp_r;
        rd_mux[`SEIE_ST_ARMED] = armed_r;
      end
      `SEIE_REG_CTRL: rd_mux[`SEIE_CTRL_PORT_EN] = port_en_r;
      `SEIE_REG_BOUND: rd_mux = 32'(bnd_r);
      `SEIE_REG_MADDR: rd_mux = 32'(maddr_r);
      `SEIE_REG_MDATA: rd_mux = 32'(mem_r[maddr_r]);
      default: rd_mux = '0;
    endcase
  end

  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_r;

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      ack_r <= 1'b0;
      o_avs_readdata <= '0;
      port_en_r <= `SEIE_PORT_EN_RST;
      maddr_r <= '0;
    end else begin
      ack_r <= (i_avs_read | i_avs_write) & ~ack_r;
      if (i_avs_read && !ack_r) begin
        o_avs_readdata <= rd_mux;
      end
      if (i_avs_write && ack_r && i_avs_byteenable[0]) begin
        if (i_avs_address == `SEIE_REG_CTRL) begin
          port_en_r <= i_avs_writedata[`SEIE_CTRL_PORT_EN];
        end else if (i_avs_address == `SEIE_REG_MADDR) begin
          maddr_r <= i_avs_writedata[AW-1:0];
        end
      end
    end
  end

endmodule // seie_engine

// ==== seie_engine_checker.sv ====
// concurrent checks on the serial eeprom instruction engine ports
// assumes binding into seie_engine; one clock domain, async high reset
`timescale 1ns/1ps

module seie_engine_checker (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire seie_pkg::seie_pins_t i_pins,
  input wire logic o_sdo,
  input wire logic o_sdo_oe,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest
);
  import seie_pkg::*;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  // --------------------------------------------------------------
  // serial output
  // --------------------------------------------------------------
  property p_oe_start;
    $rose(o_sdo_oe) |-> !o_sdo;
  endproperty
  a_oe_start: assert property (p_oe_start) else $error("output not low at drive start");
  property p_oe_sel;
    $rose(o_sdo_oe) |-> i_pins.sel && $past(i_pins.sel, 2);
  endproperty
  a_oe_sel: assert property (p_oe_sel) else $error("output driven without select");
  property p_oe_drop;
    $fell(i_pins.sel) |-> ##[1:8] !o_sdo_oe;
  endproperty
  a_oe_drop: assert property (p_oe_drop) else $error("output kept after select low");
  property p_q_fall;
    o_sdo_oe && $past(o_sdo_oe) && $fell(o_sdo) |-> i_pins.sclk;
  endproperty
  a_q_fall: assert property (p_q_fall) else $error("output fell without clock rise");
  // --------------------------------------------------------------
  // register bus
  // --------------------------------------------------------------
  property p_wait_one;
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest held too long");
  property p_idle_nowait;
    !(i_avs_read || i_avs_write) |-> !o_avs_waitrequest;
  endproperty
  a_idle_nowait: assert property (p_idle_nowait) else $error("waitrequest while idle");
  property p_rd_stands;
    !i_avs_read |=> $stable(o_avs_readdata);
  endproperty
  a_rd_stands: assert property (p_rd_stands) else $error("readdata changed without read");
  property p_unmapped;
    i_avs_read && !o_avs_waitrequest && i_avs_address > 5'h10 |-> o_avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_status_hi;
    i_avs_read && !o_avs_waitrequest && i_avs_address == 5'h00 |-> o_avs_readdata[31:5] == 27'h0;
  endproperty
  a_status_hi: assert property (p_status_hi) else $error("status upper bits set");
  c_oe: cover property ($rose(o_sdo_oe));
  c_ready: cover property (o_sdo_oe && $rose(o_sdo));
  c_write: cover property (i_avs_write && !o_avs_waitrequest);
endmodule // seie_engine_checker

bind seie_engine seie_engine_checker i_seie_engine_checker (
  .i_clk_sys(i_clk_sys),
  .i_reset(i_reset),
  .i_pins(i_pins),
  .o_sdo(o_sdo),
  .o_sdo_oe(o_sdo_oe),
  .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata),
  .i_avs_byteenable(i_avs_byteenable),
  .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest)
);

// ==== seie_master.sv ====
// serial bus master model driving select, clock, data, protect and write pins
// assumes a 250 MHz clock; serial clock period 64 ns, each level 8 cycles
`timescale 1ns/1ps

module seie_master (
  input wire logic i_clk_sys,
  input wire logic i_sdo,
  output seie_pkg::seie_pins_t o_pins
);
  import seie_pkg::*;
  int seed = 39935;
  initial o_pins = '{sel: 1'b0, sclk: 1'b0, sdi: 1'b0, pre: 1'b0, wp: 1'b1};
  // one instruction, msb first; nrd extra edges collect output bits
  task automatic frame(input logic pre, input logic [95:0] v, input int n, input int nrd,
                       output logic [63:0] q);
    q = '0;
    @(posedge i_clk_sys);
    o_pins.pre <= pre;
    o_pins.sel <= 1'b1;
    for (int i = n - 1; i >= -nrd; i--) begin
      o_pins.sdi <= (i >= 0) ? v[i] : 1'b0;
      repeat (8) @(posedge i_clk_sys);
      if (i < 0) q = {q[62:0], i_sdo};
      o_pins.sclk <= 1'b1;
      repeat (8) @(posedge i_clk_sys);
      o_pins.sclk <= 1'b0;
    end
    repeat (8) @(posedge i_clk_sys);
    o_pins.sel <= 1'b0;
    repeat (16) @(posedge i_clk_sys);
  endtask
  // write pin level, changed just after a clock edge
  task automatic wp_set(input logic v);
    @(posedge i_clk_sys);
    o_pins.wp <= v;
  endtask
  // status poll; data runs randomly and the clock toggles every 8 cycles for the first 80 cycles, then both stop
  task automatic poll(output logic b, output logic r1, output logic r2);
    repeat (70) @(posedge i_clk_sys);
    o_pins.sel <= 1'b1;
    repeat (8) @(posedge i_clk_sys);
    b = i_sdo;
    for (int k = 0; k < 600 && i_sdo !== 1'b1; k++) begin
      @(posedge i_clk_sys);
      if (k < 80) o_pins.sdi <= $random(seed);
      if (k < 80 && k % 8 == 0) o_pins.sclk <= ~o_pins.sclk;
    end
    r1 = i_sdo;
    repeat (16) @(posedge i_clk_sys);
    r2 = i_sdo;
    o_pins.sel <= 1'b0;
    repeat (16) @(posedge i_clk_sys);
  endtask
endmodule // seie_master

// ==== seie_engine_bench.sv ====
// self-checking bench for the serial eeprom instruction engine
// assumes seie_master as the serial partner and an avalon master here
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end

module seie_engine_bench;
  import seie_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  seie_pins_t pins;
  logic sdo, sdo_oe, avs_read, avs_write, avs_waitrequest;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, r;
  logic [63:0] q;
  logic [95:0] pv;
  logic [15:0] d, w;
  logic [15:0] mem_m [256];
  logic b, r1, r2;
  int checks = 0;
  int bad_count = 0;
  wire sdo_w = sdo_oe ? sdo : ~sdo;
  initial forever #2 clk_sys = ~clk_sys;
  seie_engine #(.TW_CYC(200)) i_seie_engine (.i_clk_sys(clk_sys), .i_reset(reset),
    .i_pins(pins), .o_sdo(sdo), .o_sdo_oe(sdo_oe), .i_avs_address(avs_address),
    .i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
    .i_avs_byteenable(4'hF), .o_avs_readdata(avs_readdata),
    .o_avs_waitrequest(avs_waitrequest));
  seie_master i_seie_master (.i_clk_sys(clk_sys), .i_sdo(sdo_w), .o_pins(pins));
  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] wd,
                    output logic [31:0] rd);
    @(posedge clk_sys);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= wd;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk_sys);
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic cmd(input logic pre, input logic [95:0] v, input int n, input int nrd);
    i_seie_master.frame(pre, v, n, nrd, q);
  endtask
  task automatic prog();
    i_seie_master.poll(b, r1, r2);
    `CHK(b, 1'b0)
    `CHK({r1, r2}, 2'b11)
  endtask
  task automatic mchk(input logic [7:0] a);
    av(1'b1, 5'h0C, {24'h0, a}, r);
    av(1'b0, 5'h10, 32'h0, r);
    `CHK(r, {16'h0, mem_m[a]})
  endtask
  task wrap_up();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk_sys);
    bad_count++;
    wrap_up();
  end
  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  initial begin
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h0;
    avs_writedata = 32'h0;
    foreach (mem_m[i]) mem_m[i] = 16'hFFFF;
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    av(1'b0, 5'h00, 32'h0, r);
    `CHK(r, 32'h4)
    av(1'b0, 5'h14, 32'h0, r);
    `CHK(r, 32'h0)
    av(1'b0, 5'h04, 32'h0, r);
    `CHK(r, 32'h1)
    av(1'b1, 5'h04, 32'h0, r);
    av(1'b0, 5'h04, 32'h0, r);
    `CHK(r, 32'h0)
    av(1'b1, 5'h04, 32'h1, r);
    d = $random(i_seie_master.seed);
    cmd(1'b0, {3'b101, 8'h05, d}, 27, 0);
    mchk(8'h05);
    cmd(1'b0, {3'b100, 8'hC5}, 11, 0);
    av(1'b0, 5'h00, 32'h0, r);
    `CHK(r, 32'h6)
    cmd(1'b0, {3'b101, 8'h10, d}, 27, 0);
    prog();
    mem_m[8'h10] = d;
    cmd(1'b0, {3'b110, 8'h0F}, 11, 33);
    `CHK(q[32:0], {1'b0, mem_m[8'h0F], mem_m[8'h10]})
    cmd(1'b0, {3'b101, 8'h11, ~d, 1'b0}, 28, 0);
    mchk(8'h11);
    i_seie_master.wp_set(1'b0);
    cmd(1'b0, {3'b101, 8'h12, d}, 27, 0);
    i_seie_master.wp_set(1'b1);
    mchk(8'h12);
    pv = {3'b111, 8'h22};
    for (int k = 0; k < 4; k++) begin
      w = $random(i_seie_master.seed);
      pv = {pv[79:0], w};
      mem_m[8'h20 + ((k + 2) % 4)] = w;
    end
    cmd(1'b0, pv, 75, 0);
    prog();
    for (int a = 32; a < 36; a++) mchk(a[7:0]);
    cmd(1'b1, {3'b100, 8'hC0}, 11, 0);
    cmd(1'b1, {3'b101, 8'h7D}, 11, 0);
    av(1'b0, 5'h08, 32'h0, r);
    `CHK(r, 32'h7D)
    av(1'b0, 5'h00, 32'h0, r);
    `CHK(r, 32'h2)
    cmd(1'b1, {3'b110, 8'h00}, 11, 10);
    `CHK(q[9:0], {1'b0, 8'h7D, 1'b0})
    cmd(1'b0, {3'b111, 8'h7C, d, d}, 43, 0);
    mchk(8'h7C);
    mchk(8'h7D);
    cmd(1'b0, {3'b100, 8'h40, d}, 27, 0);
    mchk(8'h00);
    cmd(1'b1, {3'b100, 8'hC0}, 11, 0);
    cmd(1'b1, {3'b111, 8'hFF}, 11, 0);
    av(1'b0, 5'h00, 32'h0, r);
    `CHK(r, 32'h6)
    d = $random(i_seie_master.seed);
    cmd(1'b0, {3'b100, 8'h7F, d}, 27, 0);
    prog();
    foreach (mem_m[i]) mem_m[i] = d;
    mchk(8'h00);
    mchk(8'hFF);
    cmd(1'b1, {3'b100, 8'hC0}, 11, 0);
    cmd(1'b1, {3'b100, 8'h00}, 11, 0);
    cmd(1'b0, {3'b100, 8'h3A}, 11, 0);
    av(1'b0, 5'h00, 32'h0, r);
    `CHK(r, 32'hC)
    wrap_up();
  end
endmodule // seie_engine_bench
